// ---- mic_consts.svh ----
// Register offsets, bit positions, reset values and vector codes
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH
// ==========================================
// Register byte offsets (Wishbone, word aligned)
`define MIC_OFS_EDGE 6'h00
`define MIC_OFS_CTL0 6'h04
`define MIC_OFS_CTL1 6'h08
`define MIC_OFS_VEC 6'h0C
`define MIC_OFS_EVST 6'h10
`define MIC_OFS_EVMASK 6'h14
// ==========================================
// Control register 0 bit positions
`define MIC_C0_TMR_FLAG 6
`define MIC_C0_RSV5 5
`define MIC_C0_PIN_FLAG 4
`define MIC_C0_TMR_EN 3
`define MIC_C0_RSV2 2
`define MIC_C0_PIN_EN 1
`define MIC_C0_GIE 0
// ==========================================
// Control register 1 bit positions
`define MIC_C1_RLD_FLAG 6
`define MIC_C1_EMP_FLAG 5
`define MIC_C1_TICK_FLAG 4
`define MIC_C1_RLD_EN 2
`define MIC_C1_EMP_EN 1
`define MIC_C1_TICK_EN 0
// ==========================================
// Reset values
`define MIC_RST_BYTE 8'h00
`define MIC_RST_EDGE 2'h0
// ==========================================
// Vector codes, in priority order
`define MIC_VEC_PIN 3'h1
`define MIC_VEC_TMR 3'h2
`define MIC_VEC_TICK 3'h3
`define MIC_VEC_EMP 3'h4
`define MIC_VEC_RLD 3'h5
`endif

// ---- mic_core_model.sv ----
// Behavioural core sequencer answering vector requests
`timescale 1ns/1ps
module mic_core_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Vector handshake
   input wire logic slow,
   input wire logic req,
   output logic ack
);
   // ==========
   // Answer
   logic [2:0] wait_reg;
   // Slow mode stalls to prove the request is held
   always_ff @(posedge clk) begin
      if (!nrst || !req || ack) begin
         ack <= 1'b0;
         wait_reg <= 3'h0;
      end else begin
         wait_reg <= wait_reg + 3'h1;
         ack <= !slow || wait_reg == 3'h5;
      end
   end
endmodule

// ---- mic_edge_det.sv ----
// External pin edge detector
`timescale 1ns/1ps
module mic_edge_det (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pin and mode
   input wire logic pin,
   input wire mic_pkg::mic_edge_t mode,
   // Detected edge pulse
   output logic hit
);
   logic prev_reg;
   logic rise;
   logic fall;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= pin; // RL17
      end
   end
   assign rise = pin & ~prev_reg;
   assign fall = ~pin & prev_reg;
   always_comb begin
      case (mode) // RL7
         mic_pkg::MIC_EDGE_RISE: hit = rise;
         mic_pkg::MIC_EDGE_FALL: hit = fall;
         mic_pkg::MIC_EDGE_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
   end
endmodule

// ---- mic_intc.sv ----
// Interrupt controller top: flags, enables, vector request, Wishbone slave
// Behaviour
// RL1 - One pin source plus timer, PWM, tick
// RL2 - Reload complete sets reload request flag
// RL3 - Buffer empty sets buffer empty flag
// RL4 - PWM interrupt needs enable and free stack
// RL5 - Accepted interrupt jumps to source vector
// RL6 - Each source has flag and enable
// RL7 - Edge field: off, rising, falling, both
// RL8 - Control 0 bit6 timer flag, bit3 enable
// RL9 - Control 0 bit4 pin flag, reset zero
// RL10 - Control 0 bit1 enables pin interrupt
// RL11 - Control 0 bit0 global enable gates all; here it gates the vector request only, not the IRQ summary output
// RL12 - Control 0 bits 5,2 reserved, unwritable
// RL13 - Control 1 holds PWM and tick bits
// RL14 - Service entry clears global enable
// RL15 - Blocked requests still latch flags
// RL16 - Service clears serviced source flag
// RL17 - Pin sampled, edges from consecutive samples
// RL18 - Fixed priority, one vector at once
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "mic_consts.svh"
module mic_intc (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic NRST,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [5:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Interrupt sources
   input wire logic PIN_IN,
   input wire logic TIMER_OVF,
   input wire logic TICK_OVF,
   input wire logic RELOAD_DONE,
   input wire logic BUFFER_EMPTY,
   // Core link
   input wire logic STACK_FULL,
   input wire logic VEC_ACK,
   output logic VEC_REQ,
   output logic [2:0] VEC_NUM,
   // Summary interrupt
   output logic IRQ
);
   // ==========================================
   // Storage
   mic_pkg::mic_edge_t edge_mode_field_reg;
   mic_pkg::mic_src_t flag_reg;
   mic_pkg::mic_src_t en_reg;
   logic global_irq_enable_reg;
   logic reserved_bit_five_reg;
   logic reserved_bit_two_reg;
   logic [4:0] evst_reg;
   logic [4:0] evmask_reg;
   mic_pkg::mic_state_t state_reg;
   mic_pkg::mic_src_t served_reg;
   logic pin_hit;
   logic buf_empty_prev_reg;
   mic_pkg::mic_src_t events;
   mic_pkg::mic_src_t ready_src;
   mic_pkg::mic_src_t win;
   logic win_any;
   logic [2:0] win_vec;
   logic take;
   logic bus_req;
   logic wr;
   logic rd;
   logic [7:0] ctl0;
   logic [7:0] ctl1;
   logic [7:0] rdata;
   // ==========================================
   // Pin edge detection
   mic_edge_det u_edge (
      .clk(SYS_CLK),
      .nrst(NRST),
      .pin(PIN_IN),
      .mode(edge_mode_field_reg),
      .hit(pin_hit)
   );
   // ==========================================
   // Source events
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         // Starts as empty so a drained buffer at reset gives no false edge
         buf_empty_prev_reg <= 1'b1;
      end else begin
         buf_empty_prev_reg <= BUFFER_EMPTY;
      end
   end
   always_comb begin
      events.pin = pin_hit; // RL1
      events.tmr = TIMER_OVF;
      events.tick = TICK_OVF;
      events.rld = RELOAD_DONE; // RL2
      events.emp = BUFFER_EMPTY & ~buf_empty_prev_reg; // RL3
   end
   // ==========================================
   // Arbitration
   // Stack full holds every source pending, not just the PWM pair
   assign ready_src = (global_irq_enable_reg && !STACK_FULL && state_reg == mic_pkg::MIC_IDLE) ?
      (flag_reg & en_reg) : '0; // RL4 RL11
   mic_prio_enc u_prio (
      .ready_src(ready_src),
      .any(win_any),
      .vec(win_vec),
      .onehot(win)
   );
   assign take = win_any;
   // ==========================================
   // Bus decode
   assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign wr = bus_req & WB_WE_I & WB_SEL_I[0];
   assign rd = bus_req & ~WB_WE_I;
   // ==========================================
   // Vector request to the core
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         state_reg <= mic_pkg::MIC_IDLE;
         VEC_REQ <= 1'b0;
         VEC_NUM <= 3'h0;
         served_reg <= '0;
      end else begin
         case (state_reg)
            mic_pkg::MIC_IDLE: begin
               if (take) begin // RL5
                  state_reg <= mic_pkg::MIC_WAIT_ACK;
                  VEC_REQ <= 1'b1;
                  VEC_NUM <= win_vec;
                  served_reg <= win;
               end
            end
            mic_pkg::MIC_WAIT_ACK: begin
               if (VEC_ACK) begin
                  state_reg <= mic_pkg::MIC_IDLE;
                  VEC_REQ <= 1'b0;
                  served_reg <= '0;
               end
            end
            default: begin
               state_reg <= mic_pkg::MIC_IDLE;
               VEC_REQ <= 1'b0;
            end
         endcase
      end
   end
   // ==========================================
   // Request flags: hardware set wins over any clear
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         flag_reg <= '0; // RL9
      end else begin
         mic_pkg::mic_src_t nxt;
         nxt = flag_reg;
         if (wr && WB_ADR_I == `MIC_OFS_CTL0) begin
            nxt.tmr = WB_DAT_I[`MIC_C0_TMR_FLAG]; // RL8
            nxt.pin = WB_DAT_I[`MIC_C0_PIN_FLAG]; // RL9
         end
         if (wr && WB_ADR_I == `MIC_OFS_CTL1) begin
            nxt.rld = WB_DAT_I[`MIC_C1_RLD_FLAG]; // RL13
            nxt.emp = WB_DAT_I[`MIC_C1_EMP_FLAG];
            nxt.tick = WB_DAT_I[`MIC_C1_TICK_FLAG];
         end
         if (state_reg == mic_pkg::MIC_IDLE && take) begin
            nxt = nxt & ~win; // RL16
         end
         flag_reg <= nxt | events; // RL6 RL15
      end
   end
   // ==========================================
   // Enables and edge mode
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         en_reg <= '0;
         edge_mode_field_reg <= mic_pkg::MIC_EDGE_OFF;
         reserved_bit_five_reg <= 1'b0;
         reserved_bit_two_reg <= 1'b0;
      end else begin
         if (wr && WB_ADR_I == `MIC_OFS_EDGE) begin
            edge_mode_field_reg <= mic_pkg::mic_edge_t'(WB_DAT_I[1:0]); // RL7
         end
         if (wr && WB_ADR_I == `MIC_OFS_CTL0) begin
            en_reg.tmr <= WB_DAT_I[`MIC_C0_TMR_EN]; // RL8
            en_reg.pin <= WB_DAT_I[`MIC_C0_PIN_EN]; // RL10
            // Reserved bits keep their value on write
            reserved_bit_five_reg <= reserved_bit_five_reg; // RL12
            reserved_bit_two_reg <= reserved_bit_two_reg; // RL12
         end
         if (wr && WB_ADR_I == `MIC_OFS_CTL1) begin
            en_reg.rld <= WB_DAT_I[`MIC_C1_RLD_EN]; // RL13
            en_reg.emp <= WB_DAT_I[`MIC_C1_EMP_EN];
            en_reg.tick <= WB_DAT_I[`MIC_C1_TICK_EN];
         end
      end
   end
   // ==========================================
   // Global enable: service entry clears it after any write
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         global_irq_enable_reg <= 1'b0;
      end else if (state_reg == mic_pkg::MIC_IDLE && take) begin
         global_irq_enable_reg <= 1'b0; // RL14
      end else if (wr && WB_ADR_I == `MIC_OFS_CTL0) begin
         global_irq_enable_reg <= WB_DAT_I[`MIC_C0_GIE]; // RL11
      end
   end
   // ==========================================
   // Event status and mask, read clears, set wins
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         evst_reg <= 5'h00;
         evmask_reg <= 5'h00;
      end else begin
         if (rd && WB_ADR_I == `MIC_OFS_EVST) begin
            evst_reg <= events;
         end else begin
            evst_reg <= evst_reg | events;
         end
         if (wr && WB_ADR_I == `MIC_OFS_EVMASK) begin
            evmask_reg <= WB_DAT_I[4:0];
         end
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |((evst_reg | events) & evmask_reg);
      end
   end
   // ==========================================
   // Read mux and acknowledge
   always_comb begin
      ctl0 = `MIC_RST_BYTE;
      ctl0[`MIC_C0_TMR_FLAG] = flag_reg.tmr;
      ctl0[`MIC_C0_RSV5] = reserved_bit_five_reg;
      ctl0[`MIC_C0_PIN_FLAG] = flag_reg.pin;
      ctl0[`MIC_C0_TMR_EN] = en_reg.tmr;
      ctl0[`MIC_C0_RSV2] = reserved_bit_two_reg;
      ctl0[`MIC_C0_PIN_EN] = en_reg.pin;
      ctl0[`MIC_C0_GIE] = global_irq_enable_reg;
      ctl1 = `MIC_RST_BYTE;
      ctl1[`MIC_C1_RLD_FLAG] = flag_reg.rld;
      ctl1[`MIC_C1_EMP_FLAG] = flag_reg.emp;
      ctl1[`MIC_C1_TICK_FLAG] = flag_reg.tick;
      ctl1[`MIC_C1_RLD_EN] = en_reg.rld;
      ctl1[`MIC_C1_EMP_EN] = en_reg.emp;
      ctl1[`MIC_C1_TICK_EN] = en_reg.tick;
      case (WB_ADR_I)
         `MIC_OFS_EDGE: rdata = {6'h00, edge_mode_field_reg};
         `MIC_OFS_CTL0: rdata = ctl0;
         `MIC_OFS_CTL1: rdata = ctl1;
         `MIC_OFS_VEC: rdata = {4'h0, VEC_REQ, VEC_NUM};
         `MIC_OFS_EVST: rdata = {3'h0, evst_reg};
         `MIC_OFS_EVMASK: rdata = {3'h0, evmask_reg};
         default: rdata = 8'h00;
      endcase
   end
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= bus_req;
         WB_DAT_O <= rd ? {24'h000000, rdata} : 32'h00000000;
      end
   end
endmodule

// ---- mic_intc_monitor.sv ----
// Port checker for the interrupt controller
`timescale 1ns/1ps
module mic_intc_monitor (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic NRST,
   // Bus
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // Core link
   input wire logic STACK_FULL,
   input wire logic VEC_ACK,
   input wire logic VEC_REQ,
   input wire logic [2:0] VEC_NUM
);
   // ==========
   // Checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   bus_answer_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
      else $error("bus request not answered");
   ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   data_high_a: assert property (WB_ACK_O |-> (WB_DAT_O[31:8] == 24'h000000))
      else $error("upper read bits not zero");
   vector_code_a: assert property ($rose(VEC_REQ) |-> (VEC_NUM inside {[3'h1:3'h5]}))
      else $error("vector code out of range");
   vector_hold_a: assert property ((VEC_REQ && !VEC_ACK) |=> (VEC_REQ && $stable(VEC_NUM)))
      else $error("vector request dropped early");
   vector_release_a: assert property ((VEC_REQ && VEC_ACK) |=> !VEC_REQ)
      else $error("vector request held after ack");
   stack_block_a: assert property ((!VEC_REQ && STACK_FULL) |=> !VEC_REQ)
      else $error("vector taken with full stack");
endmodule
bind mic_intc mic_intc_monitor mic_intc_monitor_inst (.SYS_CLK(SYS_CLK), .NRST(NRST),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .STACK_FULL(STACK_FULL), .VEC_ACK(VEC_ACK), .VEC_REQ(VEC_REQ), .VEC_NUM(VEC_NUM));

// ---- mic_pkg.sv ----
// Types shared by the interrupt controller files
package mic_pkg;
   typedef enum logic [1:0] {
      MIC_EDGE_OFF,
      MIC_EDGE_RISE,
      MIC_EDGE_FALL,
      MIC_EDGE_BOTH
   } mic_edge_t;
   // Per-source request events, one bit per source
   typedef struct packed {
      logic rld;
      logic emp;
      logic tick;
      logic tmr;
      logic pin;
   } mic_src_t;
   typedef enum {
      MIC_IDLE,
      MIC_WAIT_ACK
   } mic_state_t;
endpackage

// ---- mic_prio_enc.sv ----
// Fixed priority selector over pending enabled sources
`timescale 1ns/1ps
`include "mic_consts.svh"
module mic_prio_enc (
   // Pending and enabled sources
   input wire mic_pkg::mic_src_t ready_src,
   // Winner
   output logic any,
   output logic [2:0] vec,
   output mic_pkg::mic_src_t onehot
);
   always_comb begin
      any = 1'b1;
      vec = 3'h0;
      onehot = '0;
      if (ready_src.pin) begin // RL18
         vec = `MIC_VEC_PIN;
         onehot.pin = 1'b1;
      end else if (ready_src.tmr) begin
         vec = `MIC_VEC_TMR;
         onehot.tmr = 1'b1;
      end else if (ready_src.tick) begin
         vec = `MIC_VEC_TICK;
         onehot.tick = 1'b1;
      end else if (ready_src.emp) begin
         vec = `MIC_VEC_EMP;
         onehot.emp = 1'b1;
      end else if (ready_src.rld) begin
         vec = `MIC_VEC_RLD;
         onehot.rld = 1'b1;
      end else begin
         any = 1'b0;
      end
   end
endmodule

// ---- tb_mic_intc.sv ----
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_mic_intc;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, vack, vreq, irq;
   logic pin = 1'b0, tmr = 1'b0, tick = 1'b0, rld = 1'b0, emp = 1'b0;
   logic stk = 1'b0, slow = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [3:0] sel = 4'hF, lane = 4'hF;
   logic [31:0] dat = 32'h00000000, dat_o;
   logic [2:0] vnum;
   logic [7:0] q, e0, e1;
   int miscompares = 0, comparisons = 0;
   always #10 clk = ~clk;
   // ==========
   // Design and core
   mic_intc mic_intc_inst (.SYS_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .PIN_IN(pin), .TIMER_OVF(tmr), .TICK_OVF(tick), .RELOAD_DONE(rld),
      .BUFFER_EMPTY(emp), .STACK_FULL(stk), .VEC_ACK(vack), .VEC_REQ(vreq),
      .VEC_NUM(vnum), .IRQ(irq));
   mic_core_model mic_core_model_inst (.clk(clk), .nrst(nrst), .slow(slow), .req(vreq),
      .ack(vack));
   task cmp8(input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task cmp1(input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: flag %b want %b", $time, g, e);
      end
   endtask
   task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      {cyc, stb, we, sel, adr, dat} <= {2'b11, w, lane, a, 24'h000000, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_o[7:0];
      {cyc, stb} <= 2'b00;
   endtask
   task rd(input logic [5:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      cmp8(e, q);
   endtask
   task report_and_stop;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard, far beyond the few hundred cycles used
   initial begin
      #200000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd(6'(i * 4), 8'h00);
      // Write without lane 0 must be ignored
      lane = 4'hE;
      wb(1'b1, 6'h14, 8'h1F);
      lane = 4'hF;
      rd(6'h14, 8'h00);
      wb(1'b1, 6'h00, 8'hFF);
      rd(6'h00, 8'h03);
      wb(1'b1, 6'h04, 8'hFE);
      rd(6'h04, 8'h5A);
      wb(1'b1, 6'h08, 8'hFF);
      rd(6'h08, 8'h77);
      cmp1(1'b0, vreq);
      wb(1'b1, 6'h04, 8'h00);
      wb(1'b1, 6'h08, 8'h00);
      for (int md = 0; md < 4; md++) begin
         wb(1'b1, 6'h00, 8'(md));
         @(posedge clk) pin <= 1'b1;
         repeat (3) @(posedge clk);
         rd(6'h04, {3'h0, md[0], 4'h0});
         wb(1'b1, 6'h04, 8'h00);
         @(posedge clk) pin <= 1'b0;
         repeat (3) @(posedge clk);
         rd(6'h04, {3'h0, md[1], 4'h0});
         wb(1'b1, 6'h04, 8'h00);
      end
      rd(6'h10, 8'h01);
      rd(6'h10, 8'h00);
      wb(1'b1, 6'h14, 8'h01);
      @(posedge clk) tmr <= 1'b1;
      @(posedge clk) tmr <= 1'b0;
      repeat (3) @(posedge clk);
      cmp1(1'b0, irq);
      rd(6'h10, 8'h02);
      @(posedge clk) pin <= 1'b1;
      repeat (4) @(posedge clk);
      cmp1(1'b1, irq);
      rd(6'h10, 8'h01);
      repeat (3) @(posedge clk);
      cmp1(1'b0, irq);
      @(posedge clk) {tick, rld, emp} <= 3'h7;
      @(posedge clk) {tick, rld} <= 2'h0;
      repeat (2) @(posedge clk);
      rd(6'h08, 8'h70);
      wb(1'b1, 6'h08, 8'h77);
      stk <= 1'b1;
      wb(1'b1, 6'h04, 8'h5B);
      repeat (8) @(posedge clk);
      cmp1(1'b0, vreq);
      stk <= 1'b0;
      for (int v = 1; v < 6; v++) begin
         while (vreq !== 1'b1) begin
            @(posedge clk);
         end
         cmp8(8'(v), {5'h00, vnum});
         if (slow === 1'b1)
            rd(6'h0C, 8'(8 + v));
         while (vreq === 1'b1) begin
            @(posedge clk);
         end
         e0 = (v < 2) ? 8'h4A : 8'h0A;
         e1 = {1'b0, v < 5, v < 4, v < 3, 4'h7};
         rd(6'h04, e0);
         rd(6'h08, e1);
         slow <= ~slow;
         wb(1'b1, 6'h04, e0 | 8'h01);
      end
      // Second reset with the buffer still empty must leave every flag clear
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(6'h04, 8'h00);
      rd(6'h08, 8'h00);
      rd(6'h10, 8'h00);
      cmp1(1'b0, irq);
      report_and_stop();
   end
endmodule
